// >>> dv/alu_status_flags_bench.sv
// Self-checking bench for the ALU status flag block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin \
	compares++; \
	if ((got) !== (exp)) begin \
		n_errors++; \
		$display("wrong value %s expected %h seen %h", nm, exp, got); \
	end \
end
module alu_status_flags_bench
	import alu_flags_pkg::*;
;
	typedef struct packed {
		alu_op_type op;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] res;
		logic [4:0] f;
	} row_type;
	localparam int NROWS = 17;
	localparam row_type ROWS [NROWS] = '{
		'{OP_ADD, 8'h7F, 8'h01, 8'h80, 5'h1A},
		'{OP_ADD, 8'hFF, 8'h01, 8'h00, 5'h07},
		'{OP_SUB, 8'h05, 8'h06, 8'hFF, 5'h10},
		'{OP_SUB, 8'h80, 8'h01, 8'h7F, 5'h09},
		'{OP_AND, 8'hF0, 8'h0F, 8'h00, 5'h0D},
		'{OP_SUB, 8'h33, 8'h33, 8'h00, 5'h07},
		'{OP_OR, 8'h80, 8'h01, 8'h81, 5'h13},
		'{OP_XOR, 8'h55, 8'h55, 8'h00, 5'h07},
		'{OP_ROT_LEFT, 8'h81, 8'h00, 8'h03, 5'h03},
		'{OP_ROT_RIGHT, 8'h02, 8'h00, 8'h81, 5'h12},
		'{OP_CLEAR, 8'h00, 8'h00, 8'h00, 5'h16},
		'{OP_ROT_LEFT, 8'h00, 8'h00, 8'h00, 5'h06},
		'{OP_BIT_SET, 8'h00, 8'h03, 8'h08, 5'h06},
		'{OP_BIT_CLEAR, 8'hFF, 8'h00, 8'hFE, 5'h06},
		'{OP_NIBBLE_SWAP, 8'h12, 8'h00, 8'h21, 5'h06},
		'{OP_FILE_MOVE, 8'h00, 8'h00, 8'h00, 5'h06},
		'{OP_WREG_MOVE, 8'h80, 8'h00, 8'h80, 5'h06}
	};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [7:0] flags_out;
	exec_req_type cmd, exec_req;
	exec_rsp_type exec_rsp;
	int n_errors, compares, cyc;

	// ========
	// Design and core model
	alu_status_flags uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.exec_req(exec_req), .exec_rsp(exec_rsp), .flags_out(flags_out)
	);
	core_exec_model core (
		.pclk(pclk), .presetn(presetn), .cmd(cmd), .exec_req(exec_req)
	);

	// ========
	// Clock, timeout and verdict
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ========
	// Bus and execute tasks
	task automatic apb(input logic w, input logic [31:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		`CHK("pready", 1'b1, pready)
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic exe(input alu_op_type op, input logic [7:0] a,
		input logic [7:0] b, input logic s, input logic d);
		@(posedge pclk);
		cmd <= '{1'b1, op, a, b, s, d};
		@(posedge pclk);
		cmd <= '0;
		@(posedge pclk);
		#1;
		`CHK("rsp valid", 1'b1, exec_rsp.valid)
		`CHK("write result", ~d, exec_rsp.write_result)
	endtask

	// ========
	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		pstrb = 4'h0;
		cmd = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		`CHK("reset flags", 8'h00, flags_out)
		apb(1'b0, 32'h0, 32'h0, 4'hF);
		`CHK("reset read", 32'h0, rd)
		for (int i = 0; i < NROWS + 2; i++) begin
			@(posedge pclk);
			if (i < NROWS) begin
				cmd <= '{1'b1, ROWS[i].op, ROWS[i].a, ROWS[i].b, 1'b0, 1'b0};
			end else begin
				cmd <= '0;
			end
			#1;
			if (i >= 2) begin
				`CHK("result", ROWS[i-2].res, exec_rsp.result)
				`CHK("flags", {3'h0, ROWS[i-2].f}, flags_out)
			end
		end
		apb(1'b1, 32'h0, 32'hFF, 4'hF);
		apb(1'b1, 32'h0, 32'h0, 4'h0);
		apb(1'b0, 32'h0, 32'h0, 4'hF);
		`CHK("masked read", 32'h1F, rd)
		apb(1'b0, 32'h4, 32'h0, 4'hF);
		`CHK("bad addr err", 1'b1, err)
		`CHK("bad addr data", 32'h0, rd)
		exe(OP_ADD, 8'h7F, 8'h01, 1'b0, 1'b1);
		`CHK("dest add", 8'h1A, flags_out)
		exe(OP_CLEAR, 8'h00, 8'h00, 1'b0, 1'b1);
		`CHK("dest clear", 8'h1E, flags_out)
		exe(OP_BIT_CLEAR, 8'h00, 8'h01, 1'b1, 1'b1);
		`CHK("bit clear", 8'h1C, flags_out)
		apb(1'b0, 32'h0, 32'h0, 4'hF);
		`CHK("flags read", 32'h1C, rd)
		`CHK("flags read err", 1'b0, err)
		@(posedge pclk);
		presetn <= 1'b0;
		#1;
		`CHK("mid reset", 8'h00, flags_out)
		@(posedge pclk);
		presetn <= 1'b1;
		tally_and_finish();
	end
endmodule // alu_status_flags_bench
`default_nettype wire

// >>> dv/core_exec_model.sv
// Core execute-stage model that issues one instruction per cycle
`timescale 1ns/1ps
`default_nettype none
module core_exec_model
	import alu_flags_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire exec_req_type cmd,
	output var exec_req_type exec_req
);
	// ========
	// Issue stage; idle operands keep toggling
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exec_req <= '0;
		end else if (cmd.valid) begin
			exec_req <= cmd;
		end else begin
			exec_req.valid <= 1'b0;
			exec_req.operand_a <= ~exec_req.operand_a;
			exec_req.operand_b <= ~exec_req.operand_b;
		end
	end
endmodule // core_exec_model
`default_nettype wire

// >>> verilog/alu_flags_pkg.sv
// Package: constants, operation codes and carriers for the ALU flag block
`default_nettype none
package alu_flags_pkg;
	// ==========================================================
	// Register map and field layout
	localparam logic [31:0] FLAGS_REG_OFFSET = 32'h0000_0000;
	localparam int NEG_BIT = 4;
	localparam int OVF_BIT = 3;
	localparam int ZERO_BIT = 2;
	localparam int NIB_BIT = 1;
	localparam int CARRY_BIT = 0;
	localparam int FLAG_TOP = 4;
	localparam int SIGN_BIT = 7;
	localparam logic [2:0] UPPER_ZERO = 3'h0;
	localparam logic [4:0] FLAGS_RESET = 5'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	// ==========================================================
	// Operations issued by the execute stage
	typedef enum logic [3:0] {
		OP_ADD,
		OP_SUB,
		OP_AND,
		OP_OR,
		OP_XOR,
		OP_ROT_LEFT,
		OP_ROT_RIGHT,
		OP_CLEAR,
		OP_BIT_CLEAR,
		OP_BIT_SET,
		OP_NIBBLE_SWAP,
		OP_FILE_MOVE,
		OP_WREG_MOVE
	} alu_op_type;

	// One instruction in its execute cycle
	typedef struct packed {
		logic valid;
		alu_op_type op;
		logic [7:0] operand_a;
		logic [7:0] operand_b;
		logic src_is_flags;
		logic dest_is_flags;
	} exec_req_type;

	// Outcome handed back to the core
	typedef struct packed {
		logic valid;
		logic write_result;
		logic [7:0] result;
	} exec_rsp_type;
endpackage
`default_nettype wire

// >>> verilog/alu_status_flags.sv
// Module: status-flag generation and flags register of an 8-bit ALU
// Notes on behaviour
// RULE1: Flag-affecting instruction targeting flags register drops result, updates flags only.
// RULE2: Clear of flags register sets zero flag only, others kept, top bits zero.
// RULE3: Bits 7 to 5 read zero and ignore writes.
// RULE4: Negative flag copies result bit 7.
// RULE5: Overflow flag set on signed overflow into bit 7, else cleared.
// RULE6: Zero flag set when arithmetic or logic result is zero.
// RULE7: Add and subtract set nibble carry from carry out of bit 3.
// RULE8: Add and subtract set carry from carry out of bit 7.
// RULE9: Subtract adds two's complement; carries mean not-borrow.
// RULE10: Rotates load carry with bit shifted out of the source.
// RULE11: Bit clear, bit set, swap and moves leave all five flags alone.
// RULE12: Flags register works as source or destination of any instruction.
// RULE13: Unaffected flags hold; affected flags update at end of execute cycle.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module alu_status_flags
	import alu_flags_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire exec_req_type exec_req,
	output exec_rsp_type exec_rsp,
	output logic [7:0] flags_out
);
	// ==========================================================
	// State
	logic [4:0] flags_q, flags_d;
	exec_rsp_type rsp_q, rsp_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pslverr_q, pslverr_d;

	// ==========================================================
	// Operand selection and arithmetic
	wire [7:0] flags_byte = {UPPER_ZERO, flags_q}; // RULE3
	wire [7:0] op_a = exec_req.src_is_flags ? flags_byte : exec_req.operand_a; // RULE12
	wire [7:0] op_b = exec_req.operand_b;
	wire is_sub = exec_req.op == OP_SUB;
	wire [7:0] b_eff = is_sub ? ~op_b : op_b; // RULE9
	wire carry_in = is_sub;
	wire [8:0] sum9 = {1'b0, op_a} + {1'b0, b_eff} + {8'h00, carry_in}; // RULE8
	wire [4:0] nib5 = {1'b0, op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, carry_in}; // RULE7
	wire sum_ovf = (op_a[SIGN_BIT] == b_eff[SIGN_BIT])
		&& (sum9[SIGN_BIT] != op_a[SIGN_BIT]); // RULE5
	wire old_carry = flags_q[CARRY_BIT];
	wire [7:0] bit_mask = 8'h01 << op_b[2:0];

	// ==========================================================
	// Result and flag update per operation
	logic [7:0] res;
	logic [4:0] fl;
	logic affects;
	always_comb begin
		res = op_a;
		fl = flags_q; // RULE13
		affects = 1'b1;
		case (exec_req.op)
			OP_ADD, OP_SUB: begin
				res = sum9[7:0];
				fl[CARRY_BIT] = sum9[8]; // RULE8
				fl[NIB_BIT] = nib5[4]; // RULE7
				fl[OVF_BIT] = sum_ovf; // RULE5
			end
			OP_AND: res = op_a & op_b;
			OP_OR: res = op_a | op_b;
			OP_XOR: res = op_a ^ op_b;
			OP_ROT_LEFT: begin
				res = {op_a[6:0], old_carry};
				fl[CARRY_BIT] = op_a[SIGN_BIT]; // RULE10
			end
			OP_ROT_RIGHT: begin
				res = {old_carry, op_a[7:1]};
				fl[CARRY_BIT] = op_a[0]; // RULE10
			end
			OP_CLEAR: res = BYTE_ZERO;
			OP_BIT_CLEAR: begin
				res = op_a & ~bit_mask;
				affects = 1'b0; // RULE11
			end
			OP_BIT_SET: begin
				res = op_a | bit_mask;
				affects = 1'b0; // RULE11
			end
			OP_NIBBLE_SWAP: begin
				res = {op_a[3:0], op_a[7:4]};
				affects = 1'b0; // RULE11
			end
			OP_FILE_MOVE, OP_WREG_MOVE: begin
				res = op_a;
				affects = 1'b0; // RULE11
			end
			default: affects = 1'b0;
		endcase
		if (affects) begin
			fl[ZERO_BIT] = (res == BYTE_ZERO); // RULE6
			if (exec_req.op != OP_CLEAR) begin // RULE2
				fl[NEG_BIT] = res[SIGN_BIT]; // RULE4
			end
		end
	end

	// ==========================================================
	// APB decode
	wire apb_access = psel && penable && !pready_q;
	wire addr_hit = paddr == FLAGS_REG_OFFSET;
	wire apb_wr = psel && penable && pready_q && pwrite && addr_hit && pstrb[0];
	wire exec_go = exec_req.valid;
	wire exec_to_flags = exec_go && exec_req.dest_is_flags;

	// ==========================================================
	// Next-state selection (execute stage wins over a bus write)
	always_comb begin
		flags_d = flags_q;
		if (exec_go && affects) begin
			flags_d = fl; // RULE1
		end else if (exec_to_flags) begin
			flags_d = res[FLAG_TOP:0]; // RULE12
		end else if (apb_wr) begin
			flags_d = pwdata[FLAG_TOP:0]; // RULE3
		end
		rsp_d.valid = exec_go;
		rsp_d.write_result = exec_go && !exec_req.dest_is_flags; // RULE1
		rsp_d.result = exec_go ? res : rsp_q.result;
		prdata_d = WORD_ZERO;
		pslverr_d = 1'b0;
		if (apb_access && !addr_hit) begin
			pslverr_d = 1'b1;
		end else if (apb_access && !pwrite) begin
			prdata_d = {24'h000000, flags_byte}; // RULE3
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q <= FLAGS_RESET;
			rsp_q <= '0;
			prdata_q <= WORD_ZERO;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			flags_q <= flags_d; // RULE13
			rsp_q <= rsp_d;
			prdata_q <= prdata_d;
			pready_q <= apb_access;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign exec_rsp = rsp_q;
	assign flags_out = {UPPER_ZERO, flags_q}; // RULE3

	// ==========================================================
	// Checks
	wire plain_go = exec_go && !exec_req.dest_is_flags;
	wire [8:0] ref_add = {1'b0, op_a} + {1'b0, op_b};
	wire [4:0] ref_nib = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
	wire ref_no_borrow = op_a >= op_b;
	wire ref_ovf = (op_a[7] == op_b[7]) && (ref_add[7] != op_a[7]);
	wire [7:0] ref_diff = op_a - op_b;
	wire ref_sub_ovf = (op_a[7] != op_b[7]) && (ref_diff[7] != op_a[7]);
	wire ref_nib_no_borrow = op_a[3:0] >= op_b[3:0];

	property p_flags_dest_discard;
		@(posedge pclk) disable iff (!presetn)
		(exec_go && affects && exec_req.dest_is_flags)
		|=> (!rsp_q.write_result && rsp_q.valid && flags_q == $past(fl));
	endproperty
	a_flags_dest_discard: assert property (p_flags_dest_discard) // RULE1
		else $error("flags destination did not discard result");

	property p_clear_flags;
		@(posedge pclk) disable iff (!presetn)
		(exec_go && exec_req.op == OP_CLEAR && exec_req.dest_is_flags)
		|=> (flags_out == {3'h0, $past(flags_q[4:3]), 1'b1, $past(flags_q[1:0])});
	endproperty
	a_clear_flags: assert property (p_clear_flags) // RULE2
		else $error("clear of flags register gave wrong pattern");

	property p_upper_zero;
		@(posedge pclk) disable iff (!presetn)
		pready_q && !pslverr_q |-> (flags_out[7:5] == 3'h0 && prdata_q[31:5] == 27'h0);
	endproperty
	a_upper_zero: assert property (p_upper_zero) // RULE3
		else $error("unimplemented bits not zero");

	property p_negative;
		@(posedge pclk) disable iff (!presetn)
		(plain_go && affects && exec_req.op != OP_CLEAR)
		|=> flags_q[NEG_BIT] == rsp_q.result[7];
	endproperty
	a_negative: assert property (p_negative) // RULE4
		else $error("negative flag does not match result sign");

	property p_overflow;
		@(posedge pclk) disable iff (!presetn)
		(plain_go && exec_req.op == OP_ADD) |=> flags_q[OVF_BIT] == $past(ref_ovf);
	endproperty
	a_overflow: assert property (p_overflow) // RULE5
		else $error("overflow flag wrong after add");

	property p_zero;
		@(posedge pclk) disable iff (!presetn)
		(plain_go && affects) |=> flags_q[ZERO_BIT] == (rsp_q.result == 8'h00);
	endproperty
	a_zero: assert property (p_zero) // RULE6
		else $error("zero flag does not match result");

	property p_nibble_add;
		@(posedge pclk) disable iff (!presetn)
		(plain_go && exec_req.op == OP_ADD) |=> flags_q[NIB_BIT] == $past(ref_nib[4]);
	endproperty
	a_nibble_add: assert property (p_nibble_add) // RULE7
		else $error("nibble carry wrong after add");

	property p_carry_add;
		@(posedge pclk) disable iff (!presetn)
		(plain_go && exec_req.op == OP_ADD) |=> flags_q[CARRY_BIT] == $past(ref_add[8]);
	endproperty
	a_carry_add: assert property (p_carry_add) // RULE8
		else $error("carry wrong after add");

	property p_borrow_sub;
		@(posedge pclk) disable iff (!presetn)
		(plain_go && exec_req.op == OP_SUB)
		|=> (flags_q[CARRY_BIT] == $past(ref_no_borrow)
			&& rsp_q.result == $past(op_a) - $past(op_b));
	endproperty
	a_borrow_sub: assert property (p_borrow_sub) // RULE9
		else $error("subtract carry is not the inverted borrow");

	property p_rotate;
		@(posedge pclk) disable iff (!presetn)
		(plain_go && exec_req.op == OP_ROT_RIGHT) |=> flags_q[CARRY_BIT] == $past(op_a[0]);
	endproperty
	a_rotate: assert property (p_rotate) // RULE10
		else $error("rotate right did not load carry from bit 0");

	property p_no_flag_change;
		@(posedge pclk) disable iff (!presetn)
		(plain_go && !affects && !apb_wr) |=> $stable(flags_q);
	endproperty
	a_no_flag_change: assert property (p_no_flag_change) // RULE11
		else $error("flag-neutral instruction changed flags");

	property p_move_to_flags;
		@(posedge pclk) disable iff (!presetn)
		(exec_to_flags && !affects) |=> flags_q == $past(res[4:0]);
	endproperty
	a_move_to_flags: assert property (p_move_to_flags) // RULE12
		else $error("write of flags register as destination lost");

	property p_idle_hold;
		@(posedge pclk) disable iff (!presetn)
		(!exec_go && !apb_wr) |=> $stable(flags_q);
	endproperty
	a_idle_hold: assert property (p_idle_hold) // RULE13
		else $error("flags changed with no instruction or write");

	property p_rotate_left;
		@(posedge pclk) disable iff (!presetn)
		(plain_go && exec_req.op == OP_ROT_LEFT)
		|=> (flags_q[CARRY_BIT] == $past(op_a[SIGN_BIT])
			&& rsp_q.result == {$past(op_a[6:0]), $past(old_carry)});
	endproperty
	a_rotate_left: assert property (p_rotate_left) // RULE10
		else $error("rotate left did not move bit 7 into carry");

	property p_nibble_sub;
		@(posedge pclk) disable iff (!presetn)
		(plain_go && exec_req.op == OP_SUB)
		|=> flags_q[NIB_BIT] == $past(ref_nib_no_borrow);
	endproperty
	a_nibble_sub: assert property (p_nibble_sub) // RULE9
		else $error("nibble carry is not the inverted nibble borrow");

	property p_overflow_sub;
		@(posedge pclk) disable iff (!presetn)
		(plain_go && exec_req.op == OP_SUB)
		|=> flags_q[OVF_BIT] == $past(ref_sub_ovf);
	endproperty
	a_overflow_sub: assert property (p_overflow_sub) // RULE5
		else $error("overflow flag wrong after subtract");

	property p_logic_keep;
		@(posedge pclk) disable iff (!presetn)
		(plain_go && (exec_req.op == OP_AND || exec_req.op == OP_OR
			|| exec_req.op == OP_XOR))
		|=> ($stable(flags_q[OVF_BIT]) && $stable(flags_q[NIB_BIT])
			&& $stable(flags_q[CARRY_BIT]));
	endproperty
	a_logic_keep: assert property (p_logic_keep) // RULE13
		else $error("logic operation changed carry or overflow");

	property p_clear_plain;
		@(posedge pclk) disable iff (!presetn)
		(plain_go && exec_req.op == OP_CLEAR)
		|=> (flags_q == {$past(flags_q[4:3]), 1'b1, $past(flags_q[1:0])}
			&& rsp_q.result == BYTE_ZERO && rsp_q.write_result);
	endproperty
	a_clear_plain: assert property (p_clear_plain) // RULE2
		else $error("clear changed a flag other than zero");

	property p_bus_write;
		@(posedge pclk) disable iff (!presetn)
		(apb_wr && !exec_go) |=> flags_q == $past(pwdata[FLAG_TOP:0]);
	endproperty
	a_bus_write: assert property (p_bus_write) // RULE3
		else $error("bus write did not reach the low five flag bits");

	property p_bad_address;
		@(posedge pclk) disable iff (!presetn)
		(apb_access && !addr_hit)
		|=> (pready_q && pslverr_q && prdata_q == WORD_ZERO);
	endproperty
	a_bad_address: assert property (p_bad_address) // register address chosen for this implementation, not a rule
		else $error("access outside the flags register not refused");

	property p_read_data;
		@(posedge pclk) disable iff (!presetn)
		(apb_access && addr_hit && !pwrite)
		|=> (pready_q && !pslverr_q && prdata_q[7:0] == $past(flags_byte));
	endproperty
	a_read_data: assert property (p_read_data) // APB read interface chosen for this implementation, not a rule
		else $error("read of flags register returned wrong data");

	property p_ready_pulse;
		@(posedge pclk) disable iff (!presetn)
		pready_q |=> !pready_q;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) // APB ready timing chosen for this implementation, not a rule
		else $error("bus ready held for more than one cycle");

	property p_response;
		@(posedge pclk) disable iff (!presetn)
		exec_go |=> (rsp_q.valid
			&& rsp_q.write_result == !$past(exec_req.dest_is_flags));
	endproperty
	a_response: assert property (p_response) // RULE1
		else $error("response valid or write enable wrong");
endmodule // alu_status_flags
`default_nettype wire
